// ### hw/port_pin_config_bank.sv
`timescale 1ns/1ps
// What this block does
// - Port 1 pin n mode is low,high bit n: 00 quasi,01 push,10 in,11 drain.
// - Port 3 bit 0 takes mode from bit 0 of both port 3 selects, same code.
// - Reset sets the port 1 low select to all ones and the high to zeros.
// - Reset sets port 3 low select bit 0 to one and the high select to zero.
// - Each pin has a type bit, 0 TTL and 1 Schmitt, reset to 0.
// - Input-type registers decode only while page 1 is selected.
// - Slew regs decode on page 1 only; port 3 modes sit at AC, AD on page 0.
// - Port 1 modes sit at B3, B4 on page 0; type and slew there on page 1.
// - Dedicated bit 7 enables the pull-up while the option is 0, else always.
// - Dedicated bit 0 selects TTL or Schmitt input for the dedicated pin.
// - Slew bits reset to normal rate and a set bit selects high-speed slew.
// - Dedicated bits 3 and 2 are the timer 1 and timer 0 toggle enables.
// - An enabled toggle output flips on each overflow and starts at one.
// - The dedicated input shows its pin while the option is 0, else 0.
module port_pin_config_bank
   import pin_cfg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Register bus
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic page_select,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // Option and pins
   input wire logic reset_pin_disable_option,
   input wire logic dedicated_input_pin,
   input wire logic timer0_overflow,
   input wire logic timer1_overflow,
   // Pin configuration
   output pin_cfg_pkg::pin_mode_type port1_mode [8],
   output pin_cfg_pkg::pin_mode_type oscillator_shared_pin_mode,
   output logic [7:0] port0_schmitt,
   output logic [7:0] port1_schmitt,
   output logic port3_schmitt,
   output logic [7:0] port0_fast_slew,
   output logic [7:0] port1_fast_slew,
   output logic port3_fast_slew,
   output logic dedicated_pin_pullup_enable,
   output logic dedicated_pin_schmitt,
   output logic dedicated_pin_value,
   output logic timer0_toggle_pin,
   output logic timer1_toggle_pin
);
   import pin_cfg_pkg::*;

   logic [7:0] port1_mode_select_low;
   logic [7:0] port1_mode_select_high;
   logic port3_mode_select_low;
   logic port3_mode_select_high;
   logic [7:0] port0_input_type;
   logic [7:0] port1_input_type;
   logic port3_input_type;
   logic [7:0] port0_slew_rate;
   logic [7:0] port1_slew_rate;
   logic port3_slew_rate;
   logic [7:0] dedicated_pin_setting;
   logic [7:0] next_p1_low;
   logic [7:0] next_p1_high;
   logic next_p3_low;
   logic next_p3_high;
   logic [7:0] next_p0_type;
   logic [7:0] next_p1_type;
   logic next_p3_type;
   logic [7:0] next_p0_slew;
   logic [7:0] next_p1_slew;
   logic next_p3_slew;
   logic [7:0] next_ded;
   logic [7:0] next_rdata;
   logic next_hit;
   logic next_pullup;
   logic next_ded_value;
   logic t0_level;
   logic t1_level;
   pin_mode_type p1_mode_w [8];
   pin_mode_type p3_mode_w;

   // Paged decode used by both the write and the read path
   function automatic logic hit(input logic [7:0] addr, input logic pg,
                                input logic [7:0] ofs, input logic want);
      hit = (addr == ofs) && (pg == want);
   endfunction

   always_comb begin
      next_p1_low = port1_mode_select_low;
      next_p1_high = port1_mode_select_high;
      next_p3_low = port3_mode_select_low;
      next_p3_high = port3_mode_select_high;
      next_p0_type = port0_input_type;
      next_p1_type = port1_input_type;
      next_p3_type = port3_input_type;
      next_p0_slew = port0_slew_rate;
      next_p1_slew = port1_slew_rate;
      next_p3_slew = port3_slew_rate;
      next_ded = dedicated_pin_setting;
      if (reg_write) begin
         if (hit(reg_addr, page_select, OFS_P1_LOW, PAGE_MODE)) begin
            next_p1_low = reg_wdata;
         end
         if (hit(reg_addr, page_select, OFS_P1_HIGH, PAGE_MODE)) begin
            next_p1_high = reg_wdata;
         end
         if (hit(reg_addr, page_select, OFS_P3_LOW, PAGE_MODE)) begin
            next_p3_low = reg_wdata[0];
         end
         if (hit(reg_addr, page_select, OFS_P3_HIGH, PAGE_MODE)) begin
            next_p3_high = reg_wdata[0];
         end
         if (hit(reg_addr, page_select, OFS_P0_TYPE, PAGE_TYPE)) begin
            next_p0_type = reg_wdata;
         end
         if (hit(reg_addr, page_select, OFS_P1_LOW, PAGE_TYPE)) begin
            next_p1_type = reg_wdata;
         end
         if (hit(reg_addr, page_select, OFS_P3_LOW, PAGE_TYPE)) begin
            next_p3_type = reg_wdata[0];
         end
         if (hit(reg_addr, page_select, OFS_P0_SLEW, PAGE_TYPE)) begin
            next_p0_slew = reg_wdata;
         end
         if (hit(reg_addr, page_select, OFS_P1_HIGH, PAGE_TYPE)) begin
            next_p1_slew = reg_wdata;
         end
         if (hit(reg_addr, page_select, OFS_P3_HIGH, PAGE_TYPE)) begin
            next_p3_slew = reg_wdata[0];
         end
         // Not paged: reachable from either page
         if (reg_addr == OFS_DED) begin
            next_ded = reg_wdata & DED_USED_MASK;
         end
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      next_hit = 1'b1;
      if (hit(reg_addr, page_select, OFS_P1_LOW, PAGE_MODE)) begin
         next_rdata = port1_mode_select_low;
      end else if (hit(reg_addr, page_select, OFS_P1_HIGH, PAGE_MODE)) begin
         next_rdata = port1_mode_select_high;
      end else if (hit(reg_addr, page_select, OFS_P3_LOW, PAGE_MODE)) begin
         next_rdata = {7'h00, port3_mode_select_low};
      end else if (hit(reg_addr, page_select, OFS_P3_HIGH, PAGE_MODE)) begin
         next_rdata = {7'h00, port3_mode_select_high};
      end else if (hit(reg_addr, page_select, OFS_P0_TYPE, PAGE_TYPE)) begin
         next_rdata = port0_input_type;
      end else if (hit(reg_addr, page_select, OFS_P1_LOW, PAGE_TYPE)) begin
         next_rdata = port1_input_type;
      end else if (hit(reg_addr, page_select, OFS_P3_LOW, PAGE_TYPE)) begin
         next_rdata = {7'h00, port3_input_type};
      end else if (hit(reg_addr, page_select, OFS_P0_SLEW, PAGE_TYPE)) begin
         next_rdata = port0_slew_rate;
      end else if (hit(reg_addr, page_select, OFS_P1_HIGH, PAGE_TYPE)) begin
         next_rdata = port1_slew_rate;
      end else if (hit(reg_addr, page_select, OFS_P3_HIGH, PAGE_TYPE)) begin
         next_rdata = {7'h00, port3_slew_rate};
      end else if (reg_addr == OFS_DED) begin
         next_rdata = dedicated_pin_setting;
      end else begin
         next_hit = 1'b0;
      end
      if (!reg_read) begin
         next_hit = 1'b0;
         next_rdata = 8'h00;
      end
   end

   always_comb begin
      // Option unprogrammed forces the pull-up on and the input to zero
      next_pullup = reset_pin_disable_option
                  | dedicated_pin_setting[DED_PULLUP_BIT];
      next_ded_value = !reset_pin_disable_option
                     & dedicated_input_pin;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         port1_mode_select_low <= RST_P1_LOW;
         port1_mode_select_high <= RST_P1_HIGH;
         port3_mode_select_low <= RST_P3_LOW;
         port3_mode_select_high <= RST_P3_HIGH;
         port0_input_type <= RST_TYPE;
         port1_input_type <= RST_TYPE;
         port3_input_type <= 1'b0;
         port0_slew_rate <= RST_SLEW;
         port1_slew_rate <= RST_SLEW;
         port3_slew_rate <= 1'b0;
         dedicated_pin_setting <= RST_DED;
         reg_rdata <= 8'h00;
         reg_hit <= 1'b0;
         dedicated_pin_pullup_enable <= 1'b0;
         dedicated_pin_value <= 1'b0;
      end else begin
         port1_mode_select_low <= next_p1_low;
         port1_mode_select_high <= next_p1_high;
         port3_mode_select_low <= next_p3_low;
         port3_mode_select_high <= next_p3_high;
         port0_input_type <= next_p0_type;
         port1_input_type <= next_p1_type;
         port3_input_type <= next_p3_type;
         port0_slew_rate <= next_p0_slew;
         port1_slew_rate <= next_p1_slew;
         port3_slew_rate <= next_p3_slew;
         dedicated_pin_setting <= next_ded;
         reg_rdata <= next_rdata;
         reg_hit <= next_hit;
         dedicated_pin_pullup_enable <= next_pullup;
         dedicated_pin_value <= next_ded_value;
      end
   end

   // Mode outputs are combinational off register bits, so they follow writes
   // in the next cycle with no extra latency
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_p1
         mode_decode u_dec (
            .sel_low(port1_mode_select_low[gi]),
            .sel_high(port1_mode_select_high[gi]),
            .mode(p1_mode_w[gi])
         );
         assign port1_mode[gi] = p1_mode_w[gi];
      end
   endgenerate

   mode_decode u_dec_p3 (
      .sel_low(port3_mode_select_low),
      .sel_high(port3_mode_select_high),
      .mode(p3_mode_w)
   );
   assign oscillator_shared_pin_mode = p3_mode_w;

   assign port0_schmitt = port0_input_type;
   assign port1_schmitt = port1_input_type;
   assign port3_schmitt = port3_input_type;
   assign port0_fast_slew = port0_slew_rate;
   assign port1_fast_slew = port1_slew_rate;
   assign port3_fast_slew = port3_slew_rate;
   assign dedicated_pin_schmitt = dedicated_pin_setting[DED_TYPE_BIT];

   toggle_out u_t0 (
      .clk(clk),
      .arst_n(arst_n),
      .enable(dedicated_pin_setting[DED_T0_OE_BIT]),
      .overflow(timer0_overflow),
      .level(t0_level)
   );
   toggle_out u_t1 (
      .clk(clk),
      .arst_n(arst_n),
      .enable(dedicated_pin_setting[DED_T1_OE_BIT]),
      .overflow(timer1_overflow),
      .level(t1_level)
   );
   assign timer0_toggle_pin = t0_level;
   assign timer1_toggle_pin = t1_level;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence p1_low_write_s;
      reg_write && hit(reg_addr, page_select, OFS_P1_LOW, PAGE_MODE);
   endsequence

   p1_low_write_a: assert property (p1_low_write_s |=>
      port1_mode_select_low == $past(reg_wdata))
      else $error("port 1 low select not written");
   page_guard_a: assert property (
      reg_write && page_select == PAGE_MODE && reg_addr == OFS_P1_LOW |=>
      $stable(port1_input_type))
      else $error("input type changed on page 0");
   // Read data belongs to the address of the previous edge
   p3_unused_a: assert property (
      $past(reg_read) && $past(reg_addr) == OFS_P3_LOW |->
      reg_rdata[7:1] == 7'h00)
      else $error("port 3 unused bits read nonzero");
   ded_mask_a: assert property (
      (dedicated_pin_setting & ~DED_USED_MASK) == 8'h00)
      else $error("dedicated register unused bit set");
   pullup_force_a: assert property (reset_pin_disable_option |=>
      dedicated_pin_pullup_enable)
      else $error("pull-up not forced on");
   ded_zero_a: assert property (reset_pin_disable_option |=>
      !dedicated_pin_value)
      else $error("dedicated input not zero");
   p1_mode_map_a: assert property (
      (port1_mode[0] == MODE_INPUT_ONLY) ==
      (port1_mode_select_low[0] && !port1_mode_select_high[0]))
      else $error("port 1 input-only decode wrong");
   p1_push_map_a: assert property (
      (port1_mode[0] == MODE_PUSH_PULL) ==
      (!port1_mode_select_low[0] && port1_mode_select_high[0]))
      else $error("port 1 push-pull decode wrong");
   toggle_start_a: assert property (
      !dedicated_pin_setting[DED_T0_OE_BIT] |=> timer0_toggle_pin)
      else $error("toggle output not idle high");
   toggle_flip_a: assert property (
      dedicated_pin_setting[DED_T0_OE_BIT] && timer0_overflow |=>
      timer0_toggle_pin != $past(timer0_toggle_pin))
      else $error("toggle output missed overflow");
endmodule

// ### include/pin_cfg_pkg.sv
package pin_cfg_pkg;
   // Register offsets on the special-function-register bus
   localparam logic [7:0] OFS_P3_LOW = 8'hAC;
   localparam logic [7:0] OFS_P3_HIGH = 8'hAD;
   localparam logic [7:0] OFS_P0_TYPE = 8'hB1;
   localparam logic [7:0] OFS_P0_SLEW = 8'hB2;
   localparam logic [7:0] OFS_P1_LOW = 8'hB3;
   localparam logic [7:0] OFS_P1_HIGH = 8'hB4;
   localparam logic [7:0] OFS_DED = 8'hB5;
   // Page numbers
   localparam logic PAGE_MODE = 1'b0;
   localparam logic PAGE_TYPE = 1'b1;
   // Reset values
   localparam logic [7:0] RST_P1_LOW = 8'hFF;
   localparam logic [7:0] RST_P1_HIGH = 8'h00;
   localparam logic RST_P3_LOW = 1'b1;
   localparam logic RST_P3_HIGH = 1'b0;
   localparam logic [7:0] RST_TYPE = 8'h00;
   localparam logic [7:0] RST_SLEW = 8'h00;
   localparam logic [7:0] RST_DED = 8'h00;
   // Fields of the dedicated-pin setting register
   localparam int DED_PULLUP_BIT = 7;
   localparam int DED_T1_OE_BIT = 3;
   localparam int DED_T0_OE_BIT = 2;
   localparam int DED_TYPE_BIT = 0;
   localparam logic [7:0] DED_USED_MASK = 8'h8D;
   // Pin output modes, low bit first in the code
   typedef enum logic [1:0] {
      MODE_QUASI = 2'h0,
      MODE_PUSH_PULL = 2'h1,
      MODE_INPUT_ONLY = 2'h2,
      MODE_OPEN_DRAIN = 2'h3
   } pin_mode_type;
   localparam logic TOGGLE_START = 1'b1;
endpackage

// ### hw/mode_decode.sv
`timescale 1ns/1ps
module mode_decode
   import pin_cfg_pkg::*;
(
   // Mode-select bits of one pin
   input wire logic sel_low,
   input wire logic sel_high,
   // Decoded mode
   output pin_cfg_pkg::pin_mode_type mode
);
   assign mode = pin_mode_type'({sel_low, sel_high});
endmodule

// ### hw/toggle_out.sv
`timescale 1ns/1ps
module toggle_out
   import pin_cfg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Control
   input wire logic enable,
   input wire logic overflow,
   // Pin level
   output logic level
);
   logic next_level;
   always_comb begin
      next_level = level;
      if (!enable) begin
         // Rearm so the pin shows one again before its first overflow
         next_level = TOGGLE_START;
      end else if (overflow) begin
         next_level = ~level;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         level <= TOGGLE_START;
      end else begin
         level <= next_level;
      end
   end
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
   import pin_cfg_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic page_select = 1'b0;
   logic reset_pin_disable_option = 1'b0;
   logic dedicated_input_pin = 1'b0;
   logic timer0_overflow = 1'b0;
   logic timer1_overflow = 1'b0;
   logic [7:0] reg_rdata;
   logic reg_hit;
   pin_mode_type port1_mode [8];
   pin_mode_type oscillator_shared_pin_mode;
   logic [7:0] port0_schmitt, port1_schmitt, port0_fast_slew, port1_fast_slew;
   logic port3_schmitt, port3_fast_slew, dedicated_pin_pullup_enable;
   logic dedicated_pin_schmitt, dedicated_pin_value;
   logic timer0_toggle_pin, timer1_toggle_pin;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0001_0249;
   logic [8:0] expq [$];
   logic rd_d = 1'b0;
   logic [7:0] a, b;
   logic [7:0] ofs [6] = '{8'hAC, 8'hAD, 8'hB1, 8'hB2, 8'hB3, 8'hB4};
   logic [7:0] val [6];

   always #20 clk = ~clk;

   port_pin_config_bank dut (
      .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .page_select(page_select), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .reset_pin_disable_option(reset_pin_disable_option),
      .dedicated_input_pin(dedicated_input_pin),
      .timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
      .port1_mode(port1_mode),
      .oscillator_shared_pin_mode(oscillator_shared_pin_mode),
      .port0_schmitt(port0_schmitt), .port1_schmitt(port1_schmitt),
      .port3_schmitt(port3_schmitt), .port0_fast_slew(port0_fast_slew),
      .port1_fast_slew(port1_fast_slew), .port3_fast_slew(port3_fast_slew),
      .dedicated_pin_pullup_enable(dedicated_pin_pullup_enable),
      .dedicated_pin_schmitt(dedicated_pin_schmitt),
      .dedicated_pin_value(dedicated_pin_value),
      .timer0_toggle_pin(timer0_toggle_pin),
      .timer1_toggle_pin(timer1_toggle_pin));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   // Expected pin mode from the low and high select bits of one pin
   function automatic pin_mode_type exp_mode(input logic lo, input logic hi);
      case ({lo, hi})
         2'b01: return MODE_PUSH_PULL;
         2'b10: return MODE_INPUT_ONLY;
         2'b11: return MODE_OPEN_DRAIN;
         default: return MODE_QUASI;
      endcase
   endfunction

   task automatic rnd(output logic [7:0] v);
      seed = xs(seed);
      v = seed[7:0];
   endtask

   task automatic summarize;
      $display("counts compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic pg, input logic [7:0] ad,
                     input logic [7:0] d);
      @(negedge clk);
      page_select = pg;
      reg_addr = ad;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clk);
      reg_write = 1'b0;
   endtask

   // Expected read result is queued; the monitor compares it a cycle later
   task automatic rd(input logic pg, input logic [7:0] ad, input logic hit,
                     input logic [7:0] d);
      @(negedge clk);
      page_select = pg;
      reg_addr = ad;
      reg_read = 1'b1;
      expq.push_back({hit, d});
      @(negedge clk);
      reg_read = 1'b0;
   endtask

   task automatic pulse(input logic t0, input logic t1);
      @(negedge clk);
      timer0_overflow = t0;
      timer1_overflow = t1;
      @(negedge clk);
      timer0_overflow = 1'b0;
      timer1_overflow = 1'b0;
      // Extra cycle tolerates either one- or two-edge flip latency
      @(negedge clk);
   endtask

   always @(posedge clk) rd_d <= reg_read;

   always @(negedge clk) begin
      if (rd_d) begin
         if (expq.size() == 0)
            check(16'hFFFF, 16'h0000);
         else
            check({7'h00, reg_hit, reg_rdata},
                  {7'h00, expq.pop_front()});
      end
   end

   // Whole run is well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         summarize();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk) arst_n = 1'b1;
      @(negedge clk);
      for (int i = 0; i < 8; i++)
         check(16'(port1_mode[i]), 16'(MODE_INPUT_ONLY));
      check(16'(oscillator_shared_pin_mode), 16'(MODE_INPUT_ONLY));
      check({port0_schmitt, port1_schmitt}, 16'h0000);
      check({port0_fast_slew, port1_fast_slew}, 16'h0000);
      check(16'({timer0_toggle_pin, timer1_toggle_pin}), 16'h0003);
      rd(1'b0, 8'hB3, 1'b1, 8'hFF);
      rd(1'b0, 8'hB4, 1'b1, 8'h00);
      rd(1'b0, 8'hAC, 1'b1, 8'h01);
      rd(1'b0, 8'hAD, 1'b1, 8'h00);
      for (int j = 0; j < 6; j++)
         rd(1'b1, ofs[j], 1'b1, 8'h00);
      rd(1'b0, 8'hB5, 1'b1, 8'h00);
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         rnd(a);
         rnd(b);
         if (k == 0) begin
            a = 8'hCC;
            b = 8'hAA;
         end
         wr(1'b0, 8'hB3, a);
         wr(1'b0, 8'hB4, b);
         for (int i = 0; i < 8; i++)
            check(16'(port1_mode[i]), 16'(exp_mode(a[i], b[i])));
         rd(1'b0, 8'hB3, 1'b1, a);
         rd(1'b0, 8'hB4, 1'b1, b);
         wr(1'b0, 8'hAC, {a[7:1], k[1]});
         wr(1'b0, 8'hAD, {b[7:1], k[0]});
         check(16'(oscillator_shared_pin_mode),
               16'(exp_mode(k[1], k[0])));
         rd(1'b0, 8'hAC, 1'b1, {7'h00, k[1]});
         rd(1'b0, 8'hAD, 1'b1, {7'h00, k[0]});
      end
      $display("test modes done");
      for (int j = 0; j < 6; j++) begin
         rnd(val[j]);
         wr(1'b1, ofs[j], val[j]);
      end
      check({port0_schmitt, port1_schmitt}, {val[2], val[4]});
      check({port0_fast_slew, port1_fast_slew}, {val[3], val[5]});
      check({port3_schmitt, port3_fast_slew}, {val[0][0], val[1][0]});
      for (int j = 0; j < 6; j++)
         rd(1'b1, ofs[j], 1'b1,
            (j < 2) ? {7'h00, val[j][0]} : val[j]);
      rd(1'b0, 8'hB3, 1'b1, a);
      rd(1'b0, 8'hAC, 1'b1, 8'h01);
      wr(1'b0, 8'hB1, ~val[2]);
      check(16'(port0_schmitt), 16'(val[2]));
      rd(1'b0, 8'hB1, 1'b0, 8'h00);
      rd(1'b0, 8'hB2, 1'b0, 8'h00);
      rd(1'b1, 8'h00, 1'b0, 8'h00);
      $display("test pages done");
      wr(1'b1, 8'hB5, 8'hFF);
      @(negedge clk);
      rd(1'b0, 8'hB5, 1'b1, 8'h8D);
      check({15'h0000, dedicated_pin_pullup_enable}, 16'h0001);
      check({15'h0000, dedicated_pin_schmitt}, 16'h0001);
      wr(1'b0, 8'hB5, 8'h00);
      @(negedge clk);
      check({15'h0000, dedicated_pin_pullup_enable}, 16'h0000);
      check({15'h0000, dedicated_pin_schmitt}, 16'h0000);
      reset_pin_disable_option = 1'b1;
      dedicated_input_pin = 1'b1;
      repeat (2) @(negedge clk);
      check({15'h0000, dedicated_pin_pullup_enable}, 16'h0001);
      check({15'h0000, dedicated_pin_value}, 16'h0000);
      reset_pin_disable_option = 1'b0;
      repeat (2) @(negedge clk);
      check({15'h0000, dedicated_pin_value}, 16'h0001);
      check({15'h0000, dedicated_pin_pullup_enable}, 16'h0000);
      $display("test dedicated done");
      pulse(1'b1, 1'b1);
      check(16'({timer0_toggle_pin, timer1_toggle_pin}), 16'h0003);
      wr(1'b0, 8'hB5, 8'h04);
      check({15'h0000, timer0_toggle_pin}, 16'h0001);
      for (int n = 1; n <= 5; n++) begin
         pulse(1'b1, 1'b1);
         check(16'({timer0_toggle_pin, timer1_toggle_pin}),
               16'({~n[0], 1'b1}));
      end
      wr(1'b1, 8'hB5, 8'h08);
      pulse(1'b1, 1'b1);
      check(16'({timer0_toggle_pin, timer1_toggle_pin}), 16'h0002);
      $display("test toggle done");
      summarize();
   end
endmodule
